//--- dtb_top.v
// Purpose: Dual timer block: two 16-bit timers, joinable into a 32-bit timer or RTC.
// Assumes: APB slave, synchronous active-high reset, 100 MHz clock.
// Notes:   Interrupt level output is high while any unmasked status bit is set.
//
// Contract
// - Two 16-bit timer/counters, each independently a timer or event counter.
// - Halves combine into one 32-bit timer or 32-bit real-time clock.
// - 32-bit form offers real-time clock, one-shot and periodic countdown.
// - 16-bit halves run one-shot or periodic with optional 8-bit prescaler.
// - A 16-bit half can capture external events or generate PWM.
// - Counts or times external events on the timer input pins.
// - Timer can issue a trigger that starts an analog conversion.
// - PWM output on the pin has a software-selectable inversion.
`timescale 1ns/1ps
`include "dtb_map.vh"
module dtb_top #(
   parameter RTC_DIV = `DTB_CLK_HZ / `DTB_RTC_HZ
) (
   // Clock and reset
   input  wire        REF_CLK_IN,
   input  wire        RESET_IN,
   // APB slave
   input  wire        PSEL_IN,
   input  wire        PENABLE_IN,
   input  wire        PWRITE_IN,
   input  wire [11:0] PADDR_IN,
   input  wire [31:0] PWDATA_IN,
   output reg  [31:0] PRDATA_OUT,
   output wire        PREADY_OUT,
   output wire        PSLVERR_OUT,
   // Capture/compare/PWM pins
   input  wire        PIN_A_IN,
   input  wire        PIN_B_IN,
   output wire        PIN_A_OUT,
   output wire        PIN_B_OUT,
   // System outputs
   output reg         ADC_TRIG_OUT,
   output wire        IRQ_OUT
);

   // ****************************************************************
   // Registers
   // ****************************************************************
   reg  [1:0]  cfg_reg;
   reg  [3:0]  mode_a_reg;
   reg  [3:0]  mode_b_reg;
   reg  [15:0] ctrl_reg;
   reg  [15:0] load_a_reg;
   reg  [15:0] load_b_reg;
   reg  [15:0] match_a_reg;
   reg  [15:0] match_b_reg;
   reg  [7:0]  pre_a_reg;
   reg  [7:0]  pre_b_reg;
   reg  [`DTB_IRQ_W-1:0] istat_reg;
   reg  [`DTB_IRQ_W-1:0] imask_reg;
   reg  [31:0] cnt32_reg;
   reg  [31:0] rtc_div_reg;
   reg         run32_reg;
   reg         rl_a_reg;
   reg         rl_b_reg;

   wire        wr      = PSEL_IN & PENABLE_IN & PWRITE_IN;
   wire        split   = (cfg_reg == `DTB_CFG_SPLIT);
   wire        is_rtc  = (cfg_reg == `DTB_CFG_RTC);
   wire        en_a    = ctrl_reg[`DTB_CTRL_EN_BIT];
   wire        en_b    = ctrl_reg[`DTB_CTRL_EN_BIT + `DTB_CTRL_B_SHIFT];
   wire [31:0] load32  = {load_b_reg, load_a_reg};
   wire [15:0] val_a;
   wire [15:0] val_b;
   wire [15:0] cap_a;
   wire [15:0] cap_b;
   wire        pwm_a;
   wire        pwm_b;
   wire        to_a;
   wire        to_b;
   wire        cev_a;
   wire        cev_b;
   wire        edge_a;
   wire        edge_b;

   // Match a decoded address against a register offset.
   function hit;
      input [11:0] addr;
      input [11:0] ofs;
      begin
         hit = (addr == ofs);
      end
   endfunction

   // Zero-extend a 16-bit field into a bus word.
   function [31:0] ext16;
      input [15:0] v;
      begin
         ext16 = {16'h0000, v};
      end
   endfunction

   // Single-cycle access phase: zero wait states keep the bus simple.
   assign PREADY_OUT  = 1'b1;
   assign PSLVERR_OUT = 1'b0;

   // ****************************************************************
   // Register writes
   // ****************************************************************
   // Load writes also restart the matching 16-bit half so new periods apply at once; the joined 32-bit counter is not restarted.
   always @(posedge REF_CLK_IN) begin
      if (RESET_IN) begin
         cfg_reg     <= `DTB_CFG_SPLIT;
         mode_a_reg  <= 4'h0;
         mode_b_reg  <= 4'h0;
         ctrl_reg    <= 16'h0000;
         load_a_reg  <= `DTB_LOAD_RST;
         load_b_reg  <= `DTB_LOAD_RST;
         match_a_reg <= 16'h0000;
         match_b_reg <= 16'h0000;
         pre_a_reg   <= 8'h00;
         pre_b_reg   <= 8'h00;
         imask_reg   <= {`DTB_IRQ_W{1'b0}};
         rl_a_reg    <= 1'b0;
         rl_b_reg    <= 1'b0;
      end else begin
         rl_a_reg <= wr & (hit(PADDR_IN, `DTB_LOAD_A_OFS) | hit(PADDR_IN, `DTB_PRE_A_OFS));
         rl_b_reg <= wr & (hit(PADDR_IN, `DTB_LOAD_B_OFS) | hit(PADDR_IN, `DTB_PRE_B_OFS));
         if (wr) begin
            if (hit(PADDR_IN, `DTB_CFG_OFS))     cfg_reg     <= PWDATA_IN[1:0];
            if (hit(PADDR_IN, `DTB_MODE_A_OFS))  mode_a_reg  <= PWDATA_IN[3:0];
            if (hit(PADDR_IN, `DTB_MODE_B_OFS))  mode_b_reg  <= PWDATA_IN[3:0];
            if (hit(PADDR_IN, `DTB_CTRL_OFS))    ctrl_reg    <= PWDATA_IN[15:0];
            if (hit(PADDR_IN, `DTB_IMASK_OFS))   imask_reg   <= PWDATA_IN[`DTB_IRQ_W-1:0];
            if (hit(PADDR_IN, `DTB_LOAD_A_OFS))  load_a_reg  <= PWDATA_IN[15:0];
            if (hit(PADDR_IN, `DTB_LOAD_B_OFS))  load_b_reg  <= PWDATA_IN[15:0];
            if (hit(PADDR_IN, `DTB_MATCH_A_OFS)) match_a_reg <= PWDATA_IN[15:0];
            if (hit(PADDR_IN, `DTB_MATCH_B_OFS)) match_b_reg <= PWDATA_IN[15:0];
            if (hit(PADDR_IN, `DTB_PRE_A_OFS))   pre_a_reg   <= PWDATA_IN[7:0];
            if (hit(PADDR_IN, `DTB_PRE_B_OFS))   pre_b_reg   <= PWDATA_IN[7:0];
         end
      end
   end

   // ****************************************************************
   // Read mux
   // ****************************************************************
   // Count mode shows the running count; only time mode shows the latched capture.
   wire show_cap_a = (mode_a_reg[1:0] == `DTB_MODE_CAPTURE) & mode_a_reg[`DTB_MODE_TIME_BIT];
   wire show_cap_b = (mode_b_reg[1:0] == `DTB_MODE_CAPTURE) & mode_b_reg[`DTB_MODE_TIME_BIT];

   // Unmapped addresses read as zero.
   always @(*) begin
      PRDATA_OUT = 32'h00000000;
      if (hit(PADDR_IN, `DTB_CFG_OFS))     PRDATA_OUT = {30'h00000000, cfg_reg};
      if (hit(PADDR_IN, `DTB_MODE_A_OFS))  PRDATA_OUT = {28'h0000000, mode_a_reg};
      if (hit(PADDR_IN, `DTB_MODE_B_OFS))  PRDATA_OUT = {28'h0000000, mode_b_reg};
      if (hit(PADDR_IN, `DTB_CTRL_OFS))    PRDATA_OUT = ext16(ctrl_reg);
      if (hit(PADDR_IN, `DTB_IMASK_OFS))   PRDATA_OUT = {27'h0000000, imask_reg};
      if (hit(PADDR_IN, `DTB_ISTAT_OFS))   PRDATA_OUT = {27'h0000000, istat_reg};
      if (hit(PADDR_IN, `DTB_LOAD_A_OFS))  PRDATA_OUT = ext16(load_a_reg);
      if (hit(PADDR_IN, `DTB_LOAD_B_OFS))  PRDATA_OUT = ext16(load_b_reg);
      if (hit(PADDR_IN, `DTB_MATCH_A_OFS)) PRDATA_OUT = ext16(match_a_reg);
      if (hit(PADDR_IN, `DTB_MATCH_B_OFS)) PRDATA_OUT = ext16(match_b_reg);
      if (hit(PADDR_IN, `DTB_PRE_A_OFS))   PRDATA_OUT = {24'h000000, pre_a_reg};
      if (hit(PADDR_IN, `DTB_PRE_B_OFS))   PRDATA_OUT = {24'h000000, pre_b_reg};
      // In joined form both value words show the whole 32-bit counter.
      if (hit(PADDR_IN, `DTB_VAL_A_OFS))
         PRDATA_OUT = split ? (show_cap_a ? ext16(cap_a) : ext16(val_a)) : cnt32_reg;
      if (hit(PADDR_IN, `DTB_VAL_B_OFS))
         PRDATA_OUT = split ? (show_cap_b ? ext16(cap_b) : ext16(val_b)) : cnt32_reg;
   end

   // ****************************************************************
   // Timer halves
   // ****************************************************************
   dtb_edge u_edge_a (
      .clk_in  (REF_CLK_IN),
      .rst_in  (RESET_IN),
      .pin_in  (PIN_A_IN),
      .sel_in  (ctrl_reg[`DTB_CTRL_EDGE_LO+1:`DTB_CTRL_EDGE_LO]),
      .evt_out (edge_a)
   );

   dtb_edge u_edge_b (
      .clk_in  (REF_CLK_IN),
      .rst_in  (RESET_IN),
      .pin_in  (PIN_B_IN),
      .sel_in  (ctrl_reg[`DTB_CTRL_EDGE_LO+`DTB_CTRL_B_SHIFT+1:`DTB_CTRL_EDGE_LO+`DTB_CTRL_B_SHIFT]),
      .evt_out (edge_b)
   );

   // Halves are held disabled while joined, so their state cannot leak into 32-bit use.
   dtb_half u_half_a (
      .clk_in      (REF_CLK_IN),
      .rst_in      (RESET_IN),
      .en_in       (en_a & split),
      .mode_in     (mode_a_reg[1:0]),
      .pwm_in      (mode_a_reg[`DTB_MODE_PWM_BIT]),
      .time_in     (mode_a_reg[`DTB_MODE_TIME_BIT]),
      .inv_in      (ctrl_reg[`DTB_CTRL_INV_BIT]),
      .load_in     (load_a_reg),
      .match_in    (match_a_reg),
      .pre_in      (pre_a_reg),
      .reload_in   (rl_a_reg),
      .edge_in     (edge_a),
      .val_out     (val_a),
      .cap_out     (cap_a),
      .pwm_out     (pwm_a),
      .to_out      (to_a),
      .cap_evt_out (cev_a)
   );

   dtb_half u_half_b (
      .clk_in      (REF_CLK_IN),
      .rst_in      (RESET_IN),
      .en_in       (en_b & split),
      .mode_in     (mode_b_reg[1:0]),
      .pwm_in      (mode_b_reg[`DTB_MODE_PWM_BIT]),
      .time_in     (mode_b_reg[`DTB_MODE_TIME_BIT]),
      .inv_in      (ctrl_reg[`DTB_CTRL_INV_BIT+`DTB_CTRL_B_SHIFT]),
      .load_in     (load_b_reg),
      .match_in    (match_b_reg),
      .pre_in      (pre_b_reg),
      .reload_in   (rl_b_reg),
      .edge_in     (edge_b),
      .val_out     (val_b),
      .cap_out     (cap_b),
      .pwm_out     (pwm_b),
      .to_out      (to_b),
      .cap_evt_out (cev_b)
   );

   // PWM waveform drives the pin only in PWM mode; a running non-PWM half rests at the inversion level, a disabled or capturing half keeps its last level.
   assign PIN_A_OUT = pwm_a;
   assign PIN_B_OUT = pwm_b;

   // ****************************************************************
   // Joined 32-bit timer and real-time clock
   // ****************************************************************
   wire rtc_tick = (rtc_div_reg == RTC_DIV - 1);
   wire to32     = en_a & ~split & ~is_rtc & run32_reg & (cnt32_reg == 32'h00000000);
   wire rtc_hit  = en_a & is_rtc & rtc_tick & (cnt32_reg + 32'h00000001 == load32);

   // One-shot stops, periodic reloads, RTC counts seconds and flags when count+1 reaches the load value, then keeps counting.
   always @(posedge REF_CLK_IN) begin
      if (RESET_IN) begin
         cnt32_reg   <= 32'hFFFFFFFF;
         rtc_div_reg <= 32'h00000000;
         run32_reg   <= 1'b0;
      end else if (split | ~en_a) begin
         cnt32_reg   <= is_rtc ? 32'h00000000 : load32;
         rtc_div_reg <= 32'h00000000;
         run32_reg   <= 1'b1;
      end else if (is_rtc) begin
         rtc_div_reg <= rtc_tick ? 32'h00000000 : rtc_div_reg + 32'h00000001;
         if (rtc_tick) begin
            cnt32_reg <= cnt32_reg + 32'h00000001;
         end
      end else if (run32_reg) begin
         if (cnt32_reg != 32'h00000000) begin
            cnt32_reg <= cnt32_reg - 32'h00000001;
         end else if (mode_a_reg[1:0] == `DTB_MODE_ONESHOT) begin
            run32_reg <= 1'b0;
         end else begin
            cnt32_reg <= load32;
         end
      end
   end

   // ****************************************************************
   // Interrupts and converter trigger
   // ****************************************************************
   wire [`DTB_IRQ_W-1:0] ev = {rtc_hit, cev_b, to_b, cev_a, to_a | to32};

   // Set wins over a write-one clear arriving in the same cycle.
   always @(posedge REF_CLK_IN) begin
      if (RESET_IN) begin
         istat_reg    <= {`DTB_IRQ_W{1'b0}};
         ADC_TRIG_OUT <= 1'b0;
      end else begin
         if (wr & hit(PADDR_IN, `DTB_ISTAT_OFS)) begin
            istat_reg <= (istat_reg & ~PWDATA_IN[`DTB_IRQ_W-1:0]) | ev;
         end else begin
            istat_reg <= istat_reg | ev;
         end
         ADC_TRIG_OUT <= (ctrl_reg[`DTB_CTRL_ADC_BIT] & (to_a | to32 | rtc_hit))
                       | (ctrl_reg[`DTB_CTRL_ADC_BIT+`DTB_CTRL_B_SHIFT] & to_b);
      end
   end

   assign IRQ_OUT = |(istat_reg & imask_reg);

endmodule

//--- dtb_map.vh
// Purpose: Register offsets, field positions, reset values and timing counts of the dual timer block.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes:   Definitions only.
`ifndef DTB_MAP_VH
`define DTB_MAP_VH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define DTB_CFG_OFS        12'h000
`define DTB_MODE_A_OFS     12'h004
`define DTB_MODE_B_OFS     12'h008
`define DTB_CTRL_OFS       12'h00C
`define DTB_IMASK_OFS      12'h010
`define DTB_ISTAT_OFS      12'h014
`define DTB_LOAD_A_OFS     12'h018
`define DTB_LOAD_B_OFS     12'h01C
`define DTB_MATCH_A_OFS    12'h020
`define DTB_MATCH_B_OFS    12'h024
`define DTB_PRE_A_OFS      12'h028
`define DTB_PRE_B_OFS      12'h02C
`define DTB_VAL_A_OFS      12'h030
`define DTB_VAL_B_OFS      12'h034

// ****************************************************************
// Field positions
// ****************************************************************
// Configuration: 0 = two 16-bit halves, 1 = 32-bit timer, 2 = 32-bit RTC.
`define DTB_CFG_SPLIT      2'h0
`define DTB_CFG_JOIN       2'h1
`define DTB_CFG_RTC        2'h2
// Half mode field [1:0].
`define DTB_MODE_ONESHOT   2'h1
`define DTB_MODE_PERIODIC  2'h2
`define DTB_MODE_CAPTURE   2'h3
// Mode register bit: 1 selects PWM when mode is periodic.
`define DTB_MODE_PWM_BIT   2
// Mode register bit: capture measures time (1) or counts edges (0).
`define DTB_MODE_TIME_BIT  3
// Control register bits per half (half B at +8).
`define DTB_CTRL_EN_BIT    0
`define DTB_CTRL_EDGE_LO   2
`define DTB_CTRL_INV_BIT   6
`define DTB_CTRL_ADC_BIT   5
`define DTB_CTRL_B_SHIFT   8
// Interrupt status bits.
`define DTB_IRQ_TO_A       0
`define DTB_IRQ_CAP_A      1
`define DTB_IRQ_TO_B       2
`define DTB_IRQ_CAP_B      3
`define DTB_IRQ_RTC        4
`define DTB_IRQ_W          5

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define DTB_LOAD_RST       16'hFFFF
`define DTB_CLK_HZ         100000000
`define DTB_RTC_HZ         1

`endif

//--- dtb_edge.v
// Purpose: Detects selected edges on a timer input pin.
// Assumes: Pin input is synchronous to the clock.
// Notes:   Edge select 0 = rising, 1 = falling, 2/3 = both.
`timescale 1ns/1ps
module dtb_edge (
   // Clock and reset
   input  wire       clk_in,
   input  wire       rst_in,
   // Pin and select
   input  wire       pin_in,
   input  wire [1:0] sel_in,
   // Event
   output wire       evt_out
);

   reg pin_d_reg;

   // Delay the pin by one cycle to compare levels.
   always @(posedge clk_in) begin
      if (rst_in) begin
         pin_d_reg <= 1'b0;
      end else begin
         pin_d_reg <= pin_in;
      end
   end

   // Rising, falling or either edge as selected.
   assign evt_out = (sel_in == 2'h0) ? (pin_in & ~pin_d_reg) :
                    (sel_in == 2'h1) ? (~pin_in & pin_d_reg) : (pin_in ^ pin_d_reg);

endmodule

//--- dtb_half.v
// Purpose: One 16-bit timer half: one-shot, periodic, PWM or event capture.
// Assumes: Tick enable comes from the parent; all inputs synchronous.
// Notes:   Down counter; prescaler extends the count by eight bits.
`timescale 1ns/1ps
module dtb_half #(
   parameter WIDTH = 16,
   parameter PW    = 8
) (
   // Clock and reset
   input  wire             clk_in,
   input  wire             rst_in,
   // Configuration
   input  wire             en_in,
   input  wire [1:0]       mode_in,
   input  wire             pwm_in,
   input  wire             time_in,
   input  wire             inv_in,
   input  wire [WIDTH-1:0] load_in,
   input  wire [WIDTH-1:0] match_in,
   input  wire [PW-1:0]    pre_in,
   input  wire             reload_in,
   // Events
   input  wire             edge_in,
   // Results
   output reg  [WIDTH-1:0] val_out,
   output reg  [WIDTH-1:0] cap_out,
   output reg              pwm_out,
   output wire             to_out,
   output wire             cap_evt_out
);

   reg  [PW-1:0] pre_reg;
   reg           run_reg;
   wire          capt     = (mode_in == 2'h3);
   wire          pre_tick = (pre_reg == {PW{1'b0}});
   wire          zero     = (val_out == {WIDTH{1'b0}});
   wire          step     = en_in & run_reg & ~capt & pre_tick;

   assign to_out      = step & zero;
   assign cap_evt_out = en_in & capt & edge_in;

   // Counter, prescaler, capture latch and PWM level.
   always @(posedge clk_in) begin
      if (rst_in) begin
         pre_reg <= {PW{1'b0}};
         run_reg <= 1'b0;
         val_out <= {WIDTH{1'b1}};
         cap_out <= {WIDTH{1'b0}};
         pwm_out <= 1'b0;
      end else if (reload_in | ~en_in) begin
         // Disabling rearms a stopped one-shot so software can restart it.
         pre_reg <= pre_in;
         run_reg <= 1'b1;
         val_out <= load_in;
      end else if (capt) begin
         // Count mode decrements per edge; time mode snapshots a free-running count.
         if (time_in) begin
            val_out <= val_out - {{(WIDTH-1){1'b0}}, 1'b1};
            if (edge_in) begin
               cap_out <= val_out;
            end
         end else if (edge_in) begin
            val_out <= zero ? load_in : val_out - {{(WIDTH-1){1'b0}}, 1'b1};
            cap_out <= val_out;
         end
      end else begin
         pre_reg <= pre_tick ? pre_in : pre_reg - {{(PW-1){1'b0}}, 1'b1};
         if (step) begin
            if (!zero) begin
               val_out <= val_out - {{(WIDTH-1){1'b0}}, 1'b1};
            end else if (mode_in == 2'h1) begin
               run_reg <= 1'b0;
            end else begin
               val_out <= load_in;
            end
         end
         // Output high while count is below match, inverted on request.
         pwm_out <= inv_in ^ (pwm_in & (val_out < match_in));
      end
   end

endmodule

//--- dtb_checker.sv
// Purpose: Port-level assertions for the dual timer block.
// Assumes: Bound to dtb_top; the APB slave answers with zero wait states.
// Notes:   Sees only top-level ports; internal status is inferred from bus traffic.
`timescale 1ns/1ps
module dtb_checker (
   input wire        REF_CLK_IN,
   input wire        RESET_IN,
   input wire        PSEL_IN,
   input wire        PENABLE_IN,
   input wire        PWRITE_IN,
   input wire [11:0] PADDR_IN,
   input wire [31:0] PWDATA_IN,
   input wire [31:0] PRDATA_OUT,
   input wire        PREADY_OUT,
   input wire        PSLVERR_OUT,
   input wire        PIN_A_OUT,
   input wire        PIN_B_OUT,
   input wire        ADC_TRIG_OUT,
   input wire        IRQ_OUT
);
   default clocking cb @(posedge REF_CLK_IN); endclocking
   default disable iff (RESET_IN);
   // Transfers are taken only at the access edge.
   wire acc_w = PSEL_IN & PENABLE_IN & PWRITE_IN;
   wire acc_r = PSEL_IN & PENABLE_IN & ~PWRITE_IN;
   sequence cfg_setup_rd;
      PSEL_IN & ~PENABLE_IN & ~PWRITE_IN & (PADDR_IN == 12'h000);
   endsequence
   // The reserved encoding 3 is left out, since its readback is not defined.
   sequence cfg_write;
      acc_w & (PADDR_IN == 12'h000) & (PWDATA_IN[1:0] != 2'h3);
   endsequence
   a_ready_high: assert property (PSEL_IN |-> PREADY_OUT) else $error("ready low in a transfer");
   a_no_slverr: assert property (PSEL_IN & PENABLE_IN |-> !PSLVERR_OUT) else $error("error response");
   a_unmapped_zero: assert property (acc_r & (PADDR_IN >= 12'h038) |-> PRDATA_OUT == 32'h0)
      else $error("unmapped read not zero");
   a_setup_stable: assert property (cfg_setup_rd ##1 acc_r |-> $stable(PRDATA_OUT))
      else $error("config read changed within transfer");
   a_cfg_readback: assert property (cfg_write ##1 !PSEL_IN ##1 cfg_setup_rd
      |-> PRDATA_OUT[1:0] == $past(PWDATA_IN[1:0], 2)) else $error("config readback wrong");
   a_irq_falls_write: assert property ($fell(IRQ_OUT)
      |-> $past(acc_w & (PADDR_IN == 12'h010 || PADDR_IN == 12'h014))) else $error("irq fell by itself");
   a_mask_zero_irq: assert property (acc_w & (PADDR_IN == 12'h010) & (PWDATA_IN[4:0] == 5'h00)
      |=> !IRQ_OUT) else $error("irq high with all masked");
   a_adc_one_pulse: assert property (ADC_TRIG_OUT |=> !ADC_TRIG_OUT) else $error("trigger longer than one cycle");
   a_reset_quiet: assert property (@(posedge REF_CLK_IN) disable iff (1'b0) RESET_IN
      |=> !IRQ_OUT & !ADC_TRIG_OUT & !PIN_A_OUT & !PIN_B_OUT) else $error("outputs active after reset");
endmodule

//--- dtb_evt_src.sv
// Purpose: External event source driving a timer input pin.
// Assumes: Pin is sampled synchronously by the timer.
// Notes:   Idle level is low, as with a pull-down on the board.
`timescale 1ns/1ps
module dtb_evt_src (
   // Clock and control
   input  wire       clk_in,
   input  wire       go_in,
   input  wire [7:0] count_in,
   // Pin
   output wire       pin_out
);
   reg [7:0] left_reg = 8'h00;
   reg [1:0] ph_reg   = 2'h0;
   reg       pin_reg  = 1'b0;
   assign pin_out = pin_reg;
   // Each pulse is two cycles high and two low, so a sampling edge detector never misses one.
   always @(posedge clk_in) begin
      if (go_in) begin
         left_reg <= count_in;
         ph_reg <= 2'h0;
      end else if (left_reg != 8'h00) begin
         ph_reg <= ph_reg + 2'h1;
         pin_reg <= ~ph_reg[1];
         if (ph_reg == 2'h3) begin
            left_reg <= left_reg - 8'h01;
         end
      end else begin
         pin_reg <= 1'b0;
      end
   end
endmodule

//--- dtb_tb.sv
// Purpose: Self-checking bench for the dual timer block.
// Assumes: Zero-wait APB slave; RTC divider shortened to ten cycles.
// Notes:   Trigger pulses are timed to measure timer periods exactly.
`timescale 1ns/1ps
`include "dtb_map.vh"
module testbench;
   reg         clk = 1'b0;
   reg         rst = 1'b1;
   reg         psel = 1'b0;
   reg         penable = 1'b0;
   reg         pwrite = 1'b0;
   reg  [11:0] paddr = 12'h000;
   reg  [31:0] pwdata = 32'h0;
   reg         go = 1'b0;
   reg  [7:0]  npulse = 8'h00;
   wire [31:0] prdata;
   wire        pready, pslverr, pin_a, out_a, out_b, adc, irq;
   reg  [31:0] rv;
   integer     mismatches = 0;
   integer     tests_run = 0;
   integer     cyc = 0, adc_cnt = 0, adc_last = 0, adc_gap = 0;
   integer     i, k, hi, hia;
   always #5 clk = ~clk;
   dtb_top #(.RTC_DIV(10)) dtb_top_i (.REF_CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
      .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
      .PSLVERR_OUT(pslverr), .PIN_A_IN(pin_a), .PIN_B_IN(pin_a), .PIN_A_OUT(out_a), .PIN_B_OUT(out_b),
      .ADC_TRIG_OUT(adc), .IRQ_OUT(irq));
   dtb_evt_src dtb_evt_src_i (.clk_in(clk), .go_in(go), .count_in(npulse), .pin_out(pin_a));
   // The gap between trigger pulses gives the timer period with no bus latency in it.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (adc === 1'b1) begin
         adc_cnt <= adc_cnt + 1;
         adc_gap <= cyc - adc_last;
         adc_last <= cyc;
      end
   end
   task chk(input [255:0] nm, input [31:0] exp, input [31:0] got);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("[FAIL] %0s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   // One APB transfer; the request is held until pready is seen high.
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         @(posedge clk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge clk);
         penable <= 1'b1;
         // Only the watchdog ends a wait for the answer.
         @(posedge clk);
         while (pready !== 1'b1) begin
            @(posedge clk);
         end
         rv = prdata;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task rchk(input [255:0] nm, input [11:0] a, input [31:0] exp);
      begin
         apb(1'b0, a, 32'h0);
         chk(nm, exp, rv);
      end
   endtask
   task wait_irq(input integer lim, input exp);
      integer n;
      begin
         n = 0;
         @(posedge clk);
         while (irq !== exp && n < lim) begin
            @(posedge clk);
            n = n + 1;
         end
         chk("irq", {31'h0, exp}, {31'h0, irq});
      end
   endtask
   task conclude;
      begin
         if (mismatches == 0 && tests_run > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   // The whole sequence needs about 9000 cycles; the limit leaves wide margin.
   initial begin
      #500000;
      mismatches = mismatches + 1;
      conclude;
   end
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rchk("load_a", `DTB_LOAD_A_OFS, 32'h0000FFFF);
      rchk("val_a", `DTB_VAL_A_OFS, 32'h0000FFFF);
      apb(1'b1, 12'h040, 32'hFFFFFFFF);
      rchk("unmapped", 12'h040, 32'h0);
      apb(1'b1, `DTB_CFG_OFS, 32'h1);
      rchk("cfg", `DTB_CFG_OFS, 32'h1);
      apb(1'b1, `DTB_LOAD_A_OFS, 32'h3);
      apb(1'b1, `DTB_LOAD_B_OFS, 32'h1);
      rchk("val_joined", `DTB_VAL_A_OFS, 32'h00010003);
      // Joined one-shot must flag once and then stay stopped.
      apb(1'b1, `DTB_LOAD_B_OFS, 32'h0);
      apb(1'b1, `DTB_LOAD_A_OFS, 32'd50);
      apb(1'b1, `DTB_MODE_A_OFS, 32'h1);
      apb(1'b1, `DTB_IMASK_OFS, 32'h1);
      apb(1'b1, `DTB_CTRL_OFS, 32'h21);
      wait_irq(300, 1'b1);
      rchk("istat_to", `DTB_ISTAT_OFS, 32'h1);
      repeat (200) @(posedge clk);
      chk("oneshot_trig", 32'd1, adc_cnt);
      apb(1'b1, `DTB_IMASK_OFS, 32'h0);
      wait_irq(2, 1'b0);
      apb(1'b1, `DTB_IMASK_OFS, 32'h1);
      wait_irq(2, 1'b1);
      apb(1'b1, `DTB_ISTAT_OFS, 32'h1F);
      wait_irq(2, 1'b0);
      // A stopped one-shot only restarts through a disable or a return to split form, so rearm for periodic.
      apb(1'b1, `DTB_CTRL_OFS, 32'h0);
      apb(1'b1, `DTB_MODE_A_OFS, 32'h2);
      apb(1'b1, `DTB_LOAD_A_OFS, 32'd30);
      apb(1'b1, `DTB_CTRL_OFS, 32'h21);
      repeat (200) @(posedge clk);
      chk("periodic32", 32'd31, adc_gap);
      apb(1'b1, `DTB_CTRL_OFS, 32'h0);
      // Real-time clock: one count every ten cycles, flag when count+1 equals load.
      apb(1'b1, `DTB_ISTAT_OFS, 32'h1F);
      apb(1'b1, `DTB_CFG_OFS, 32'h2);
      apb(1'b1, `DTB_LOAD_A_OFS, 32'h3);
      apb(1'b1, `DTB_IMASK_OFS, 32'h10);
      apb(1'b1, `DTB_CTRL_OFS, 32'h1);
      wait_irq(100, 1'b1);
      apb(1'b0, `DTB_ISTAT_OFS, 32'h0);
      chk("rtc_flag", 32'h1, {31'h0, rv[4]});
      apb(1'b1, `DTB_CTRL_OFS, 32'h0);
      apb(1'b1, `DTB_ISTAT_OFS, 32'h1F);
      apb(1'b1, `DTB_CFG_OFS, 32'h0);
      // Half B periodic with prescaler, boundary value 255 included.
      apb(1'b1, `DTB_MODE_B_OFS, 32'h2);
      apb(1'b1, `DTB_LOAD_B_OFS, 32'd9);
      for (k = 0; k < 3; k = k + 1) begin
         hi = (k == 0) ? 0 : (k == 1) ? 3 : 255;
         apb(1'b1, `DTB_PRE_B_OFS, hi);
         apb(1'b1, `DTB_CTRL_OFS, 32'h2100);
         repeat (30 * (hi + 1) + 20) @(posedge clk);
         chk("period_b", 10 * (hi + 1), adc_gap);
         apb(1'b1, `DTB_CTRL_OFS, 32'h0);
      end
      // Edge counting on half A for rising, falling and both edges.
      apb(1'b1, `DTB_MODE_A_OFS, 32'h3);
      for (k = 0; k < 3; k = k + 1) begin
         apb(1'b1, `DTB_CTRL_OFS, (k << 2) | 1);
         apb(1'b1, `DTB_LOAD_A_OFS, 32'd100);
         npulse <= 8'd5;
         go <= 1'b1;
         @(posedge clk);
         go <= 1'b0;
         repeat (40) @(posedge clk);
         rchk("edge_count", `DTB_VAL_A_OFS, (k == 2) ? 32'd90 : 32'd95);
      end
      apb(1'b1, `DTB_CTRL_OFS, 32'h0);
      // PWM on both halves: three of every ten counts lie below the match value.
      apb(1'b1, `DTB_PRE_B_OFS, 32'h0);
      apb(1'b1, `DTB_MODE_B_OFS, 32'h6);
      apb(1'b1, `DTB_MATCH_B_OFS, 32'd3);
      apb(1'b1, `DTB_MODE_A_OFS, 32'h6);
      apb(1'b1, `DTB_MATCH_A_OFS, 32'd3);
      apb(1'b1, `DTB_LOAD_A_OFS, 32'd9);
      for (k = 0; k < 2; k = k + 1) begin
         apb(1'b1, `DTB_CTRL_OFS, (k == 0) ? 32'h101 : 32'h4141);
         repeat (20) @(posedge clk);
         hi = 0;
         hia = 0;
         for (i = 0; i < 100; i = i + 1) begin
            @(posedge clk);
            hi = hi + (out_b === 1'b1);
            hia = hia + (out_a === 1'b1);
         end
         chk("pwm_high", (k == 0) ? 32'd30 : 32'd70, hi);
         chk("pwm_a_high", (k == 0) ? 32'd30 : 32'd70, hia);
      end
      conclude;
   end
endmodule
bind dtb_top dtb_checker dtb_checker_i (.REF_CLK_IN(REF_CLK_IN), .RESET_IN(RESET_IN), .PSEL_IN(PSEL_IN),
   .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
   .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .PIN_A_OUT(PIN_A_OUT),
   .PIN_B_OUT(PIN_B_OUT), .ADC_TRIG_OUT(ADC_TRIG_OUT), .IRQ_OUT(IRQ_OUT));
